/* File: common/fsp_regs.vh */
`ifndef FSP_REGS_VH
`define FSP_REGS_VH

// apb register byte offsets
`define FSP_CTRL_OFS     12'h000
`define FSP_POINTER_OFS  12'h004
`define FSP_DATA_OFS     12'h008
`define FSP_PROG_OFS     12'h00C
`define FSP_STATUS_OFS   12'h010

// command patterns of the control register
`define FSP_CMD_LOAD     8'h01
`define FSP_CMD_ERASE    8'h03
`define FSP_CMD_WRITE    8'h05
`define FSP_CMD_NONE     8'h00

// control register fields
`define FSP_ENABLE_BIT   0
`define FSP_CLEAR_BIT    4

// status register fields
`define FSP_ST_BUSY_BIT  0
`define FSP_ST_ARMED_BIT 1
`define FSP_ST_EE_BIT    2

// arming window in processor cycles
`define FSP_ARM_WINDOW   3'h4

// erase/write duration: least time, rounded up to whole cycles
`define FSP_CLK_NS       10
`define FSP_OP_TIME_NS   3700000
`define FSP_OP_CYCLES    ((`FSP_OP_TIME_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

// values
`define FSP_ERASED_WORD  16'hFFFF
`define FSP_BUSY_BYTE    8'hFF

`endif

/* File: rtl/fsp_flash_self_program_sequencer.v */
// Overview of operation
// - pattern 03 then store-program erases page
// - erase ignores data and non-page pointer bits
// - processor stalled during whole page erase
// - pattern 01 loads data word into buffer
// - buffer cleared: page write, clear bit, reset
// - eeprom write during loading discards buffer
// - pattern 05 programs buffer into page
// - processor stalled during whole page write
// - low pointer bits word, high bits page
// - byte read uses pointer bit zero
// - buffer loads accepted in any order
// - store-program from anywhere; no reads while busy
// - eeprom write blocks programming commands
// - armed command lapses after four cycles
// - erase/write lasts at least 3.7 ms
`timescale 1ns/1ns
`include "fsp_regs.vh"

module fsp_flash_self_program_sequencer
#(
  parameter        PAGE_WORDS = 32,
  parameter        PAGE_COUNT = 64,
  parameter [23:0] OP_CYCLES  = `FSP_OP_CYCLES
)
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        spm_exec,
  input  wire        eeprom_write_busy_bit,
  output reg         cpu_stall
);

  localparam WB  = $clog2(PAGE_WORDS);
  localparam PGB = $clog2(PAGE_COUNT);
  localparam FW  = WB + PGB;

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_BUSY  = 3'b100;

  reg  [2:0]     state;
  reg  [7:0]     cmd;
  reg  [2:0]     arm_cnt;
  reg  [15:0]    pointer;
  reg  [15:0]    data_word_pair;
  reg  [PGB-1:0] op_page;
  reg            op_is_write;
  reg  [23:0]    busy_cnt;
  reg            ee_prev;
  reg  [15:0]    page_buf  [0:PAGE_WORDS-1];
  reg  [15:0]    flash_mem [0:PAGE_WORDS*PAGE_COUNT-1];
  reg  [31:0]    next_prdata;
  reg            next_pslverr;
  reg  [15:0]    rd_word;
  integer        i;
  integer        k;

  // the pointer is a byte address; bit zero picks the byte of a word
  function [WB-1:0] word_of;
    input [15:0] ptr;
    begin
      word_of = ptr[WB:1];
    end
  endfunction

  function [PGB-1:0] page_of;
    input [15:0] ptr;
    begin
      page_of = ptr[FW:WB+1];
    end
  endfunction

  wire setup_acc = psel & penable & ~pready;
  wire wr_done   = psel & penable & pready & pwrite;
  wire wr_ctrl   = wr_done & (paddr == `FSP_CTRL_OFS);
  wire ee_event  = eeprom_write_busy_bit & ~ee_prev;
  wire busy      = (state == ST_BUSY);
  wire armed     = (state == ST_ARMED);
  wire exec_ok   = armed & spm_exec & ~eeprom_write_busy_bit;
  wire op_done   = busy & (busy_cnt == OP_CYCLES - 24'h000001);
  // only an idle or armed sequencer with a quiet eeprom takes commands
  wire cmd_ok    = wr_ctrl & ~busy & ~eeprom_write_busy_bit;
  wire is_cmd    = (pwdata[7:0] == `FSP_CMD_LOAD) |
                   (pwdata[7:0] == `FSP_CMD_ERASE) |
                   (pwdata[7:0] == `FSP_CMD_WRITE);
  wire clr_req   = cmd_ok & pwdata[`FSP_CLEAR_BIT] & pwdata[`FSP_ENABLE_BIT];
  wire buf_clear = clr_req | ee_event |
                   (op_done & op_is_write);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ee_prev <= 1'b0;
    end
    else
    begin
      ee_prev <= eeprom_write_busy_bit;
    end
  end

  // command arming, window and operation timing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= ST_IDLE;
      cmd         <= `FSP_CMD_NONE;
      arm_cnt     <= 3'h0;
      op_page     <= {PGB{1'b0}};
      op_is_write <= 1'b0;
      busy_cnt    <= 24'h000000;
      cpu_stall   <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (cmd_ok & is_cmd)
          begin
            state   <= ST_ARMED;
            cmd     <= pwdata[7:0];
            arm_cnt <= 3'h0;
          end
        end
        ST_ARMED:
        begin
          arm_cnt <= arm_cnt + 3'h1;
          if (exec_ok)
          begin
            cmd <= `FSP_CMD_NONE;
            if (cmd == `FSP_CMD_LOAD)
            begin
              state <= ST_IDLE;
            end
            else
            begin
              // page field only; other pointer bits do not matter here
              state       <= ST_BUSY;
              op_page     <= page_of(pointer);
              op_is_write <= (cmd == `FSP_CMD_WRITE);
              busy_cnt    <= 24'h000000;
              cpu_stall   <= 1'b1;
            end
          end
          else if (cmd_ok & is_cmd)
          begin
            cmd     <= pwdata[7:0];
            arm_cnt <= 3'h0;
          end
          else if (arm_cnt == `FSP_ARM_WINDOW - 3'h1)
          begin
            state <= ST_IDLE;
            cmd   <= `FSP_CMD_NONE;
          end
        end
        ST_BUSY:
        begin
          busy_cnt <= busy_cnt + 24'h000001;
          if (op_done)
          begin
            state     <= ST_IDLE;
            cpu_stall <= 1'b0;
          end
        end
        default:
        begin
          state     <= ST_IDLE;
          cmd       <= `FSP_CMD_NONE;
          cpu_stall <= 1'b0;
        end
      endcase
    end
  end

  // temporary page buffer; a clear outranks a load in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < PAGE_WORDS; i = i + 1)
      begin
        page_buf[i] <= `FSP_ERASED_WORD;
      end
    end
    else if (buf_clear)
    begin
      for (i = 0; i < PAGE_WORDS; i = i + 1)
      begin
        page_buf[i] <= `FSP_ERASED_WORD;
      end
    end
    else if (exec_ok & (cmd == `FSP_CMD_LOAD))
    begin
      // any word order is fine
      page_buf[word_of(pointer)] <= data_word_pair;
    end
  end

  // the array changes only when the timed operation ends
  always @(posedge pclk)
  begin
    if (op_done)
    begin
      for (k = 0; k < PAGE_WORDS; k = k + 1)
      begin
        if (op_is_write)
        begin
          // programming only pulls bits low, as real cells do
          flash_mem[{op_page, k[WB-1:0]}] <=
            flash_mem[{op_page, k[WB-1:0]}] & page_buf[k];
        end
        else
        begin
          flash_mem[{op_page, k[WB-1:0]}] <= `FSP_ERASED_WORD;
        end
      end
    end
  end

  // software-written pointer and data word
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pointer        <= 16'h0000;
      data_word_pair <= 16'h0000;
    end
    else if (wr_done)
    begin
      if (paddr == `FSP_POINTER_OFS)
      begin
        pointer <= pwdata[15:0];
      end
      if (paddr == `FSP_DATA_OFS)
      begin
        data_word_pair <= pwdata[15:0];
      end
    end
  end

  // read decode
  always @*
  begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    rd_word      = flash_mem[pointer[FW:1]];
    case (paddr)
      `FSP_CTRL_OFS:
      begin
        next_prdata[7:0] = cmd;
      end
      `FSP_POINTER_OFS:
      begin
        next_prdata[15:0] = pointer;
      end
      `FSP_DATA_OFS:
      begin
        next_prdata[15:0] = data_word_pair;
      end
      `FSP_PROG_OFS:
      begin
        // the array cannot be read while it is being changed
        if (busy)
        begin
          next_prdata[7:0] = `FSP_BUSY_BYTE;
        end
        else if (pointer[0])
        begin
          next_prdata[7:0] = rd_word[15:8];
        end
        else
        begin
          next_prdata[7:0] = rd_word[7:0];
        end
      end
      `FSP_STATUS_OFS:
      begin
        next_prdata[`FSP_ST_BUSY_BIT]  = busy;
        next_prdata[`FSP_ST_ARMED_BIT] = armed;
        next_prdata[`FSP_ST_EE_BIT]    = eeprom_write_busy_bit;
      end
      default:
      begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  // one wait state: read data and error are registered with pready
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup_acc;
      if (setup_acc)
      begin
        prdata  <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= next_pslverr;
      end
      else
      begin
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

endmodule // fsp_flash_self_program_sequencer

/* File: bench/fsp_sequencer_assertions.sv */
`timescale 1ns/1ns
module fsp_sequencer_assertions
#(
  parameter [23:0] OP_CYCLES = 24'h000014
)
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        spm_exec,
  input wire        eeprom_write_busy_bit,
  input wire        cpu_stall
);
  reg [3:0]  age;
  reg [23:0] len;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // saturates so a stale arming never looks fresh again
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      age <= 4'hF;
    else if (psel && penable && pready && pwrite && paddr == 12'h000)
      age <= 4'h0;
    else if (age != 4'hF)
      age <= age + 4'h1;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      len <= 24'h0;
    else
      len <= cpu_stall ? len + 24'h1 : 24'h0;
  property p_cause; $rose(cpu_stall) |-> $past(spm_exec); endproperty
  a_cause: assert property (p_cause) else $error("stall cause");
  property p_ee; $rose(cpu_stall) |-> !$past(eeprom_write_busy_bit); endproperty
  a_ee: assert property (p_ee) else $error("eeprom block");
  property p_win; $rose(cpu_stall) |-> age <= 4'h4; endproperty
  a_win: assert property (p_win) else $error("arm window");
  property p_hold; $rose(cpu_stall) |-> cpu_stall [*8]; endproperty
  a_hold: assert property (p_hold) else $error("stall hold");
  property p_len; $fell(cpu_stall) |-> len == OP_CYCLES; endproperty
  a_len: assert property (p_len) else $error("op length");
  property p_brd;
    pready && cpu_stall && !pwrite && paddr == 12'h00C |-> prdata == 32'h000000FF;
  endproperty
  a_brd: assert property (p_brd) else $error("busy read");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("apb wait");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("apb pulse");
endmodule // fsp_sequencer_assertions

bind fsp_flash_self_program_sequencer fsp_sequencer_assertions #(.OP_CYCLES(OP_CYCLES)) u_chk
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .spm_exec(spm_exec),
  .eeprom_write_busy_bit(eeprom_write_busy_bit), .cpu_stall(cpu_stall)
);

/* File: bench/fsp_cpu_model.sv */
`timescale 1ns/1ns
module fsp_cpu_model
(
  input  wire       pclk,
  input  wire       presetn,
  input  wire       go,
  input  wire [3:0] gap,
  output reg        spm_exec
);
  reg [3:0] cnt;
  // a large gap lets the bench miss the arming window on purpose
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt <= 4'h0;
      spm_exec <= 1'b0;
    end
    else
    begin
      cnt <= go ? gap : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
      spm_exec <= cnt == 4'h1;
    end
endmodule // fsp_cpu_model

/* File: bench/test_flash_self_program_sequencer.sv */
`timescale 1ns/1ns
`include "fsp_regs.vh"
module test_flash_self_program_sequencer;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         eeb = 1'b0;
  reg         go = 1'b0;
  reg  [3:0]  gap = 4'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        spm_exec;
  wire        cpu_stall;
  reg  [31:0] rd;
  reg  [31:0] rv;
  reg         er;
  reg  [15:0] eb [0:31];
  integer     seed = 26148;
  integer     err_total = 0;
  integer     checks_done = 0;
  integer     i;
  always #5 pclk = ~pclk;
  fsp_flash_self_program_sequencer #(.OP_CYCLES(24'h000014)) dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spm_exec(spm_exec), .eeprom_write_busy_bit(eeb), .cpu_stall(cpu_stall)
  );
  fsp_cpu_model cpu
  (
    .pclk(pclk), .presetn(presetn), .go(go), .gap(gap), .spm_exec(spm_exec)
  );
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
    begin
      checks_done = checks_done + 1;
      if (s !== e)
      begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      // one idle edge keeps psel from being lowered and raised in one step
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50 && pready !== 1'b1; n = n + 1)
        @(posedge pclk);
      if (pready !== 1'b1)
      begin
        err_total = err_total + 1;
        $display("CHECK FAILED pready exp 1 got %b", pready);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task cmd(input [7:0] c, input [3:0] g, input x);
    integer n;
    reg     s;
    begin
      if (c != 8'h00)
        apb(1'b1, 12'h000, {24'h0, c});
      go <= 1'b1;
      gap <= g;
      @(posedge pclk);
      go <= 1'b0;
      s = 1'b0;
      for (n = 0; n < 60; n = (s && cpu_stall === 1'b0) ? 60 : n + 1)
      begin
        @(posedge pclk);
        if (cpu_stall === 1'b1 && !s)
        begin
          s = 1'b1;
          apb(1'b0, 12'h00C, 32'h0);
          chk("busy rd", 32'hFF, rd);
          apb(1'b0, 12'h010, 32'h0);
          chk("status", 32'h1, rd);
        end
      end
      chk("stall", {31'h0, x}, {31'h0, s});
      chk("unstall", 32'h0, {31'h0, cpu_stall});
    end
  endtask
  task wipe;
    for (i = 0; i < 32; i = i + 1)
      eb[i] = 16'hFFFF;
  endtask
  task load(input [4:0] w, input [15:0] d);
    begin
      apb(1'b1, 12'h004, {26'h0, w, 1'b0});
      apb(1'b1, 12'h008, {16'h0, d});
      cmd(`FSP_CMD_LOAD, 4'h1, 1'b0);
      eb[w] = d;
    end
  endtask
  task prog(input [5:0] p, input [15:0] j);
    begin
      apb(1'b1, 12'h004, {20'h0, p, j[5:0]});
      apb(1'b1, 12'h008, {16'h0, j});
      cmd(`FSP_CMD_ERASE, 4'h2, 1'b1);
      apb(1'b1, 12'h004, {20'h0, p, 6'h0});
      cmd(`FSP_CMD_WRITE, 4'h1, 1'b1);
    end
  endtask
  function [7:0] xb(input [5:0] b);
    xb = b[0] ? eb[b[5:1]][15:8] : eb[b[5:1]][7:0];
  endfunction
  task chkpg(input [5:0] p, input [63:0] nm);
    integer w;
    begin
      for (w = 0; w < 64; w = w + 1)
      begin
        apb(1'b1, 12'h004, {20'h0, p, w[5:0]});
        apb(1'b0, 12'h00C, 32'h0);
        chk(nm, {24'h0, xb(w[5:0])}, rd);
      end
      $display("test %0s done", nm);
      wipe;
    end
  endtask
  initial
  begin
    wipe;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    $display("test regs done");
    for (i = 31; i >= 0; i = i - 3)
    begin
      rv = $random(seed);
      load(i[4:0], rv[15:0]);
    end
    prog(6'h05, rv[31:16]);
    chkpg(6'h05, "load");
    // buffer must come back empty after the previous page write
    prog(6'h06, 16'h0);
    chkpg(6'h06, "autoclr");
    load(5'h07, 16'h1234);
    apb(1'b1, 12'h000, 32'h11);
    wipe;
    prog(6'h07, 16'h0);
    chkpg(6'h07, "clrbit");
    load(5'h02, 16'h00F0);
    eeb <= 1'b1;
    cmd(`FSP_CMD_ERASE, 4'h1, 1'b0);
    eeb <= 1'b0;
    wipe;
    prog(6'h08, 16'h0);
    chkpg(6'h08, "eeprom");
    load(5'h00, 16'h0000);
    wipe;
    apb(1'b1, 12'h004, {20'h0, 6'h08, 6'h0});
    cmd(`FSP_CMD_WRITE, 4'h3, 1'b0);
    cmd(8'h00, 4'h1, 1'b0);
    chkpg(6'h08, "late");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    prog(6'h09, 16'h0);
    chkpg(6'h09, "reset");
    stop_test;
  end
  initial
  begin
    #500000;
    err_total = err_total + 1;
    stop_test;
  end
endmodule // test_flash_self_program_sequencer
